// ### hdl/dse_core.sv
// Core-side debug-state entry and hold logic.
// Assumes the pipeline front end supplies fetch, execute and flush events.
//
// Notes on behaviour
// - Monitor marks an instruction after its data phase
// - Mark on load/store data means watchpoint
// - Acknowledge raised on real debug entry
// - Tag at fetch, halt only at execute
// - Branch flush discards pending breakpoint tags
// - Exception flush cancels tags; refetch retags
// - Tagged conditional always halts regardless
// - Breakpointed instruction is never executed
// - Watchpoint waits for instruction end, never lost
// - Watchpointed instruction commits all its results
// - Pending exception mode kept on watch entry
// - Debug request from comparator or pin
// - Pin request synchronised, taken at end
// - Coprocessor busy-wait abandoned on request
// - Memory request pair shows internal cycles
// - Aborts and interrupts ignored while halted
// - Endian select held during debug
// - Core reset held inactive (high) during debug
// - Byte latch enables high while halted
// - Other outputs may move while halted
// - Memory controller tolerates such movement
// - Instructions enter serially while isolated
`timescale 1ns/10ps
module dse_core
    import dse_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    // Link to the system
    dse_if.core             lnk,
    // Pipeline events
    input  wire logic       fetch_valid,
    input  wire logic       data_is_ldst,
    input  wire logic       exec_adv,
    input  wire logic       instr_done,
    input  wire logic       branch_flush,
    input  wire logic       exc_flush,
    input  wire logic       exc_pending,
    input  wire logic       cp_busy_wait,
    input  wire logic       comp_debug_req,
    input  wire logic       core_mem_req_n,
    input  wire logic       core_seq,
    input  wire logic       core_abort,
    input  wire logic       resume,
    input  wire logic       scan_instr_valid,
    // Status to the core
    output logic            halted,
    output logic            exec_inhibit,
    output logic            cp_abandon,
    output logic            abort_taken,
    output logic            irq_taken,
    output logic            fiq_taken,
    output logic            exc_mode_kept,
    output logic            scan_instr_take,
    output dse_cause_t      entry_cause
);
    //----------------------------------------------------------------
    // State
    //----------------------------------------------------------------
    logic [1:0] sync_r, sync_nxt;
    logic [1:0] tag_r, tag_nxt;     // Decode and execute stage tags
    logic       watch_r, watch_nxt;
    logic       req_r, req_nxt;
    logic       halt_r, halt_nxt;
    logic       ack_r, ack_nxt;
    logic       mreq_r, mreq_nxt;
    logic       seq_r, seq_nxt;
    logic       inh_r, inh_nxt;
    logic       cpab_r, cpab_nxt;
    logic       ab_r, ab_nxt, irq_r, irq_nxt, fiq_r, fiq_nxt;
    logic       mode_r, mode_nxt, stake_r, stake_nxt;
    dse_cause_t cause_r, cause_nxt;

    //----------------------------------------------------------------
    // Next-state logic
    //----------------------------------------------------------------
    // Entry decisions and output forcing
    always_comb
    begin
        logic brk_hit;
        logic watch_hit;
        logic req_hit;
        logic bp_fetch;
        brk_hit   = 1'b0;
        watch_hit = 1'b0;
        req_hit   = 1'b0;
        bp_fetch  = lnk.ext_break_mark & fetch_valid & ~data_is_ldst;
        sync_nxt  = {sync_r[0], lnk.debug_req_in};
        tag_nxt   = tag_r;
        watch_nxt = watch_r;
        req_nxt   = req_r;
        halt_nxt  = halt_r;
        cause_nxt = cause_r;
        mode_nxt  = mode_r;
        cpab_nxt  = 1'b0;
        if (!halt_r)
        begin
            // Tags move with the pipeline; flushes clear them
            if (exec_adv)
                tag_nxt = {tag_r[0], bp_fetch};
            else if (bp_fetch)
                tag_nxt[0] = 1'b1;
            if (branch_flush | exc_flush)
                tag_nxt = 2'h0;
            if (lnk.ext_break_mark & data_is_ldst)
                watch_nxt = 1'b1;
            if (sync_r[1] | comp_debug_req)
                req_nxt = 1'b1;
            // Tagged instruction at execute halts, condition ignored
            brk_hit   = tag_r[1] & ~branch_flush & ~exc_flush;
            watch_hit = watch_r & instr_done;
            req_hit   = req_r & (instr_done | cp_busy_wait);
            cpab_nxt  = req_r & cp_busy_wait & ~brk_hit & ~watch_hit;
            if (brk_hit | watch_hit | req_hit)
            begin
                halt_nxt  = 1'b1;
                tag_nxt   = 2'h0;
                // A watch mark landing now outlives this entry
                watch_nxt = (watch_r & ~watch_hit) |
                            (lnk.ext_break_mark & data_is_ldst);
                req_nxt   = 1'b0;
                mode_nxt  = watch_hit & exc_pending;
                cause_nxt = brk_hit ? DSE_CAUSE_BREAK :
                            watch_hit ? DSE_CAUSE_WATCH : DSE_CAUSE_REQ;
            end
        end
        else if (resume)
        begin
            halt_nxt  = 1'b0;
            cause_nxt = DSE_CAUSE_NONE;
            mode_nxt  = 1'b0;
        end
        // Breakpoint stops execution; watchpoint lets it commit
        inh_nxt   = brk_hit | (halt_nxt & ~resume);
        ack_nxt   = halt_nxt;
        mreq_nxt  = halt_nxt ? MEM_REQ_N_IDLE : core_mem_req_n;
        seq_nxt   = halt_nxt ? SEQ_IDLE : core_seq;
        ab_nxt    = ~halt_nxt & core_abort;
        irq_nxt   = ~halt_nxt & ~lnk.irq_req_n;
        fiq_nxt   = ~halt_nxt & ~lnk.fast_irq_req_n;
        stake_nxt = halt_r & scan_instr_valid;
    end

    //----------------------------------------------------------------
    // Registers
    //----------------------------------------------------------------
    // State update, frozen while clk_en is low
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sync_r  <= SYNC_RST;
            tag_r   <= 2'h0;
            watch_r <= 1'b0;
            req_r   <= 1'b0;
            halt_r  <= 1'b0;
            ack_r   <= ACK_RST;
            mreq_r  <= MEM_REQ_N_IDLE;
            seq_r   <= SEQ_IDLE;
            inh_r   <= 1'b0;
            cpab_r  <= 1'b0;
            ab_r    <= 1'b0;
            irq_r   <= 1'b0;
            fiq_r   <= 1'b0;
            mode_r  <= 1'b0;
            stake_r <= 1'b0;
            cause_r <= DSE_CAUSE_NONE;
        end
        else if (clk_en)
        begin
            sync_r  <= sync_nxt;
            tag_r   <= tag_nxt;
            watch_r <= watch_nxt;
            req_r   <= req_nxt;
            halt_r  <= halt_nxt;
            ack_r   <= ack_nxt;
            mreq_r  <= mreq_nxt;
            seq_r   <= seq_nxt;
            inh_r   <= inh_nxt;
            cpab_r  <= cpab_nxt;
            ab_r    <= ab_nxt;
            irq_r   <= irq_nxt;
            fiq_r   <= fiq_nxt;
            mode_r  <= mode_nxt;
            stake_r <= stake_nxt;
            cause_r <= cause_nxt;
        end
    end

    //----------------------------------------------------------------
    // Outputs
    //----------------------------------------------------------------
    // Straight from flip-flops
    assign lnk.debug_ack_out     = ack_r;
    assign lnk.mem_req_n         = mreq_r;
    assign lnk.sequential_access = seq_r;
    assign halted                = halt_r;
    assign exec_inhibit          = inh_r;
    assign cp_abandon            = cpab_r;
    assign abort_taken           = ab_r;
    assign irq_taken             = irq_r;
    assign fiq_taken             = fiq_r;
    assign exc_mode_kept         = mode_r;
    assign scan_instr_take       = stake_r;
    assign entry_cause           = cause_r;
endmodule : dse_core

// ### hdl/dse_pkg.sv
// Package for the debug-state entry block: shared encodings and constants.
// Assumes a single ref_clk domain and a synchronous active-high reset.
package dse_pkg;
    // Internal-cycle encoding of the memory request pair
    localparam logic MEM_REQ_N_IDLE   = 1'b1;
    localparam logic SEQ_IDLE         = 1'b0;
    // Reset values and the all-high byte latch enable value
    localparam logic ACK_RST          = 1'b0;
    localparam logic [1:0] SYNC_RST   = 2'h0;
    localparam logic [3:0] BLE_ALL    = 4'hF;
    // Debug entry cause codes
    typedef enum logic [1:0] {
        DSE_CAUSE_NONE,
        DSE_CAUSE_BREAK,
        DSE_CAUSE_WATCH,
        DSE_CAUSE_REQ
    } dse_cause_t;
endpackage : dse_pkg

// ### hdl/dse_if.sv
// Interface joining the core-side debug entry logic and the system side.
// Assumes both ends share ref_clk.
`timescale 1ns/10ps
interface dse_if;
    logic       ext_break_mark;
    logic       debug_req_in;
    logic       debug_ack_out;
    logic       mem_req_n;
    logic       sequential_access;
    logic       endian_select;
    logic       core_rst_n;
    logic [3:0] byte_latch_en;
    logic       irq_req_n;
    logic       fast_irq_req_n;

    modport core (
        input  ext_break_mark, debug_req_in, endian_select, core_rst_n,
               byte_latch_en, irq_req_n, fast_irq_req_n,
        output debug_ack_out, mem_req_n, sequential_access
    );
    modport sys (
        output ext_break_mark, debug_req_in, endian_select, core_rst_n,
               byte_latch_en, irq_req_n, fast_irq_req_n,
        input  debug_ack_out, mem_req_n, sequential_access
    );
endinterface : dse_if

// ### hdl/dse_sys.sv
// System side: break marking, debug request and held inputs.
// Assumes the user side presents fetched data classification each cycle.
`timescale 1ns/10ps
module dse_sys
    import dse_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    // Link to the core
    dse_if.sys              lnk,
    // User side
    input  wire logic       mark_hit,
    input  wire logic       dbg_request,
    input  wire logic       endian_req,
    input  wire logic       rst_req,
    input  wire logic       irq_req,
    input  wire logic       fiq_req,
    output logic            in_debug,
    output logic            mem_idle
);
    logic mark_r, mark_nxt, dreq_r, dreq_nxt, end_r, end_nxt;
    logic crst_r, crst_nxt, irq_r, irq_nxt, fiq_r, fiq_nxt;
    logic dbg_r, dbg_nxt, idle_r, idle_nxt;

    // Mark drives for the edge after data valid; endian frozen, core reset held high
    always_comb
    begin
        mark_nxt = mark_hit;
        dreq_nxt = dbg_request;
        end_nxt  = lnk.debug_ack_out ? end_r : endian_req;
        crst_nxt = lnk.debug_ack_out ? 1'b1 : ~rst_req;
        irq_nxt  = ~irq_req;
        fiq_nxt  = ~fiq_req;
        dbg_nxt  = lnk.debug_ack_out;
        // Idle encoding noticed so address motion is ignored
        idle_nxt = lnk.mem_req_n & ~lnk.sequential_access;
    end

    // Registers, frozen while clk_en is low
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            mark_r <= 1'b0;
            dreq_r <= 1'b0;
            end_r  <= 1'b0;
            crst_r <= 1'b1;
            irq_r  <= 1'b1;
            fiq_r  <= 1'b1;
            dbg_r  <= 1'b0;
            idle_r <= 1'b1;
        end
        else if (clk_en)
        begin
            mark_r <= mark_nxt;
            dreq_r <= dreq_nxt;
            end_r  <= end_nxt;
            crst_r <= crst_nxt;
            irq_r  <= irq_nxt;
            fiq_r  <= fiq_nxt;
            dbg_r  <= dbg_nxt;
            idle_r <= idle_nxt;
        end
    end

    // Link and user outputs
    assign lnk.ext_break_mark = mark_r;
    assign lnk.debug_req_in   = dreq_r;
    assign lnk.endian_select  = end_r;
    assign lnk.core_rst_n     = crst_r;
    assign lnk.byte_latch_en  = BLE_ALL;
    assign lnk.irq_req_n      = irq_r;
    assign lnk.fast_irq_req_n = fiq_r;
    assign in_debug           = dbg_r;
    assign mem_idle           = idle_r;
endmodule : dse_sys

// ### test/dse_checker.sv
// Checker on the link between the core and system ends.
// Assumes the link signals and the shared clock and reset are wired in.
`timescale 1ns/10ps
module dse_checker
    import dse_pkg::*;
(
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // Link signals
    input wire logic       ext_break_mark,
    input wire logic       debug_req_in,
    input wire logic       debug_ack_out,
    input wire logic       mem_req_n,
    input wire logic       sequential_access,
    input wire logic       endian_select,
    input wire logic       core_rst_n,
    input wire logic [3:0] byte_latch_en,
    input wire logic       irq_req_n,
    input wire logic       fast_irq_req_n
);
    // ---
    // Link properties
    // ---
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_halt_req_idle: assert property (
        debug_ack_out |-> mem_req_n == MEM_REQ_N_IDLE)
        else $error("request not idle while halted");
    chk_halt_seq_idle: assert property (
        debug_ack_out |-> sequential_access == SEQ_IDLE)
        else $error("sequential not idle while halted");
    chk_endian_frozen: assert property (
        debug_ack_out && $past(debug_ack_out) |-> $stable(endian_select))
        else $error("endian select moved while halted");
    chk_core_rst_held: assert property (
        debug_ack_out && $past(debug_ack_out) |-> core_rst_n)
        else $error("core reset driven while halted");
    chk_latch_all_high: assert property (
        debug_ack_out |-> byte_latch_en == BLE_ALL)
        else $error("byte latch enables low while halted");
    chk_ack_after_reset: assert property (
        $fell(rst) |-> debug_ack_out == ACK_RST && mem_req_n)
        else $error("acknowledge set out of reset");
    chk_req_sync_delay: assert property (
        $rose(debug_req_in) && !debug_ack_out
        |-> !debug_ack_out [*3] ##[1:40] debug_ack_out)
        else $error("request entry timing wrong");
    chk_break_at_exec: assert property (
        $rose(ext_break_mark) && !debug_ack_out |-> !debug_ack_out [*2])
        else $error("break entry before execute");

    // Main scenarios reached
    cover property ($rose(debug_ack_out));
    cover property (debug_ack_out && !irq_req_n);
    cover property (debug_ack_out && !fast_irq_req_n);
endmodule : dse_checker

// ### test/tb_top.sv
// Bench joining the core and system ends through the link.
// Assumes package, link, both ends and checker are compiled first.
`timescale 1ns/10ps
module tb_top
    import dse_pkg::*;
;
    // ---
    // Bench state and ends
    // ---
    typedef struct packed {dse_cause_t cause; logic kept;} dse_note_t;
    dse_note_t  notes[$];
    dse_note_t  note;
    dse_cause_t entry_cause;
    int         seed = 40929;
    int         mismatches = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic       clk_en = 1'b1;
    logic       ack_q = 1'b0;
    logic       fetch_valid, data_is_ldst, exec_adv, instr_done;
    logic       branch_flush, exc_flush, exc_pending, cp_busy_wait;
    logic       comp_debug_req, core_mem_req_n, core_seq, core_abort;
    logic       resume, scan_instr_valid, mark_hit, dbg_request;
    logic       endian_req, rst_req, irq_req, fiq_req, in_debug, mem_idle;
    logic       halted, exec_inhibit, cp_abandon, abort_taken, irq_taken;
    logic       fiq_taken, exc_mode_kept, scan_instr_take;

    dse_if      lnk ();
    dse_core    dse_core_i (.*);
    dse_sys     dse_sys_i (.*);
    dse_checker dse_checker_i (.ref_clk(ref_clk), .rst(rst),
        .ext_break_mark(lnk.ext_break_mark),
        .debug_req_in(lnk.debug_req_in),
        .debug_ack_out(lnk.debug_ack_out), .mem_req_n(lnk.mem_req_n),
        .sequential_access(lnk.sequential_access),
        .endian_select(lnk.endian_select), .core_rst_n(lnk.core_rst_n),
        .byte_latch_en(lnk.byte_latch_en), .irq_req_n(lnk.irq_req_n),
        .fast_irq_req_n(lnk.fast_irq_req_n));

    // Free-running clock
    always #5 ref_clk = ~ref_clk;

    // Step a cycle, new random bus values
    task automatic tick(input int c = 1);
        repeat (c)
        begin
            @(posedge ref_clk);
            #1;
            {core_mem_req_n, core_seq, endian_req} = 3'($random(seed));
        end
    endtask : tick

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : check

    // Marked fetch held two cycles
    task automatic fetch(input logic ldst);
        {mark_hit, fetch_valid, data_is_ldst} = {2'b11, ldst};
        tick(2);
        {mark_hit, fetch_valid, data_is_ldst} = 3'h0;
    endtask : fetch

    // Await entry, poke ignored inputs, then resume
    task automatic hold_debug();
        for (int i = 0; i < 30 && lnk.debug_ack_out !== 1'b1; i++)
            tick();
        {irq_req, fiq_req, core_abort, scan_instr_valid, rst_req} = 5'h1F;
        tick(3);
        check(8'({abort_taken, irq_taken, fiq_taken}), 8'h0);
        check(8'({halted, exec_inhibit, in_debug, mem_idle,
                  lnk.debug_ack_out}), 8'h1F);
        check(8'(scan_instr_take), 8'h1);
        {scan_instr_valid, rst_req} = 2'h0;
        tick();
        resume = 1'b1;
        tick();
        resume = 1'b0;
        tick();
        check(8'(lnk.debug_ack_out), 8'h0);
        // Ignored inputs act again once running
        check(8'({abort_taken, irq_taken, fiq_taken}), 8'h7);
        {irq_req, fiq_req, core_abort} = 3'h0;
        tick(2);
    endtask : hold_debug

    // Verdict and end of run
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    // Main sequence
    initial
    begin
        {fetch_valid, data_is_ldst, exec_adv, instr_done, branch_flush,
         exc_flush, exc_pending, cp_busy_wait, comp_debug_req, core_abort,
         resume, scan_instr_valid, mark_hit, dbg_request, rst_req,
         irq_req, fiq_req, core_mem_req_n, core_seq, endian_req} = 20'h0;
        tick(5);
        rst = 1'b0;
        // Branch flush, exception flush, then refetched break
        for (int k = 0; k < 3; k++)
        begin
            fetch(1'b0);
            branch_flush = (k == 0);
            exc_flush = (k == 1);
            if (k == 2)
                notes.push_back('{DSE_CAUSE_BREAK, 1'b0});
            tick();
            {branch_flush, exc_flush, exec_adv} = 3'b001;
            tick();
            exec_adv = 1'b0;
            if (k == 2)
                hold_debug();
            else
                tick(6);
        end
        // Watch waits for the access to end, keeps pending mode
        exc_pending = 1'b1;
        notes.push_back('{DSE_CAUSE_WATCH, 1'b1});
        fetch(1'b1);
        tick(4);
        check(8'(lnk.debug_ack_out), 8'h0);
        // Frozen clock enable holds the pending watch
        clk_en = 1'b0;
        instr_done = 1'b1;
        tick(2);
        check(8'({lnk.debug_ack_out, halted}), 8'h0);
        clk_en = 1'b1;
        tick();
        instr_done = 1'b0;
        hold_debug();
        exc_pending = 1'b0;
        // Pin request, pin request in busy-wait, comparator request
        for (int k = 0; k < 3; k++)
        begin
            notes.push_back('{DSE_CAUSE_REQ, 1'b0});
            dbg_request = (k < 2);
            comp_debug_req = (k == 2);
            cp_busy_wait = (k == 1);
            tick(5);
            check(8'(cp_abandon), 8'(k == 1));
            tick();
            if (k == 0)
                check(8'(lnk.debug_ack_out), 8'h0);
            instr_done = (k != 1);
            tick();
            {instr_done, dbg_request, comp_debug_req, cp_busy_wait} = 4'h0;
            hold_debug();
        end
        check(8'(notes.size()), 8'h0);
        conclude();
    end

    // Each new entry matched with the oldest note; hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (!rst && lnk.debug_ack_out === 1'b1 && !ack_q)
        begin
            if (notes.size() == 0)
                check(8'h1, 8'h0);
            else
            begin
                note = notes.pop_front();
                check(8'({entry_cause, exc_mode_kept}), 8'(note));
            end
        end
        ack_q = lnk.debug_ack_out;
        if (cycles == 2000)
        begin
            mismatches++;
            conclude();
        end
    end
endmodule : tb_top
